/* File: rtl/fscr_pkg.sv */
/*
 * Shared constants and types of the flash system-call requester.
 * Assumes one 20 MHz clock and a device register port with read data
 * valid one cycle after the read strobe.
 */
`default_nettype none

package fscr_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned TIMEOUT_MS  = 1000;
    localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;

    // ==========================================================
    // Device-side call registers (index on the device port)
    localparam logic DEV_SEL_ARG = 1'b0;
    localparam logic DEV_SEL_REQ = 1'b1;

    // Field layout of the device request register
    localparam int REQ_BIT_START   = 31;
    localparam int REQ_BIT_PRIV    = 28;
    localparam int OPC_LSB         = 0;
    localparam int OPC_W           = 8;
    localparam logic [7:0] OPC_HI_FILL = 8'h00;

    // Guard keys and completion status patterns
    localparam logic [7:0]  KEY_FIRST      = 8'hb6;
    localparam logic [7:0]  KEY_SECOND_BASE = 8'hd3;
    localparam logic [3:0]  STAT_OK_NIB    = 4'ha;
    localparam logic [23:0] STAT_FAIL_MID  = 24'hf00000;

    // ==========================================================
    // Software register map of the controller (byte addresses)
    localparam int SW_AW = 5;
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_ARG     = 5'h04;
    localparam logic [4:0] OFS_STATUS  = 5'h08;
    localparam logic [4:0] OFS_RES_ARG = 5'h0c;
    localparam logic [4:0] OFS_RES_REQ = 5'h10;

    // CTRL fields
    localparam int CTRL_BIT_SRAM  = 8;
    localparam int CTRL_BIT_START = 31;

    // STATUS fields
    localparam int ST_BIT_BUSY    = 0;
    localparam int ST_BIT_DONE    = 1;
    localparam int ST_BIT_OK      = 2;
    localparam int ST_BIT_FAIL    = 3;
    localparam int ST_BIT_TIMEOUT = 4;
    localparam int ST_BIT_REFUSED = 5;
    localparam int ST_CODE_LSB    = 8;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ==========================================================
    // Types
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_WARG = 7'h02,
        ST_WREQ = 7'h04,
        ST_PRD  = 7'h08,
        ST_PCHK = 7'h10,
        ST_SRD  = 7'h20,
        ST_SCHK = 7'h40
    } fscr_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        sel;
        logic [31:0] wdata;
    } fscr_dev_req_t;

endpackage

`default_nettype wire

/* File: rtl/fscr_host.sv */
/*
 * Debug-port side requester of flash system calls: builds guard keys,
 * writes argument and request registers of the device, polls for the
 * end of the call, times out after one second and collects the status.
 * Assumes the device register port answers a read in the next cycle
 * and that software drives the plain command port below.
 */
`default_nettype none

module fscr_host #(
    parameter int unsigned TIMEOUT_CYC = fscr_pkg::TIMEOUT_CYC,
    parameter logic [7:0]  NB_OPC_A    = 8'hff,
    parameter logic [7:0]  NB_OPC_B    = 8'hfe,
    parameter logic [7:0]  NB_OPC_C    = 8'hfd
) (
    // Clock and reset
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET_N,
    // Software command port
    input  wire logic [fscr_pkg::SW_AW-1:0] I_ADDR,
    input  wire logic [31:0]             I_WDATA,
    input  wire logic                    I_WR,
    input  wire logic                    I_RD,
    output logic      [31:0]             O_RDATA,
    // Device state
    input  wire logic                    I_PROG_MODE,
    output logic                         O_CALL_BUSY,
    // Device register port
    output var fscr_pkg::fscr_dev_req_t  O_DEV_REQ,
    input  wire logic [31:0]             I_DEV_RDATA
);

    // ==========================================================
    // Parameter check
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("TIMEOUT_CYC must be at least 2");
    end

    // Three distinct codes, or one of the non-blocking calls slips through
    if (NB_OPC_A == NB_OPC_B || NB_OPC_A == NB_OPC_C
        || NB_OPC_B == NB_OPC_C) begin : g_bad_nb_opc
        $error("NB_OPC_A, NB_OPC_B and NB_OPC_C must all differ");
    end

    // The poll needs two separate flags inside one 32-bit word
    if (fscr_pkg::REQ_BIT_PRIV == fscr_pkg::REQ_BIT_START
        || fscr_pkg::REQ_BIT_PRIV > 31) begin : g_bad_flags
        $error("REQ_BIT_PRIV must be a free bit of the request word");
    end

    // ==========================================================
    // Storage
    fscr_pkg::fscr_state_t state_ff;
    fscr_pkg::fscr_state_t nxt_state;
    logic [7:0]  opcode_ff;
    logic        use_sram_ff;
    logic [31:0] arg_ff;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic [31:0] timer_ff;
    logic [31:0] res_arg_ff;
    logic [31:0] res_req_ff;
    logic        done_ff;
    logic        ok_ff;
    logic        fail_ff;
    logic        timeout_ff;
    logic        refused_ff;
    logic [7:0]  code_ff;
    logic [31:0] rdata_ff;

    // ==========================================================
    // Software decode
    wire sel_ctrl    = (I_ADDR == fscr_pkg::OFS_CTRL);
    wire sel_arg     = (I_ADDR == fscr_pkg::OFS_ARG);
    wire sel_status  = (I_ADDR == fscr_pkg::OFS_STATUS);
    wire sel_res_arg = (I_ADDR == fscr_pkg::OFS_RES_ARG);
    wire sel_res_req = (I_ADDR == fscr_pkg::OFS_RES_REQ);

    wire is_idle     = (state_ff == fscr_pkg::ST_IDLE);
    wire wr_ctrl     = I_WR && sel_ctrl && is_idle;
    wire start_req   = wr_ctrl && I_WDATA[fscr_pkg::CTRL_BIT_START];
    wire [7:0] new_opc = I_WDATA[fscr_pkg::OPC_LSB +: fscr_pkg::OPC_W];

    // Non-blocking calls belong to the processor, never to this port
    // They also need processor code and a handler in SRAM to resume them
    wire opc_nb = (new_opc == NB_OPC_A) || (new_opc == NB_OPC_B)
               || (new_opc == NB_OPC_C);
    // The debug port may only call while the target is held for programming
    wire start_ok  = start_req && I_PROG_MODE && !opc_nb;
    wire start_bad = start_req && !start_ok;

    // ==========================================================
    // Words sent to the device
    // Register mode puts both keys in the low half of the argument
    wire [7:0]  key_second = fscr_pkg::KEY_SECOND_BASE + new_opc;
    wire [31:0] arg_regs   = {arg_ff[31:16], key_second, fscr_pkg::KEY_FIRST};
    // SRAM mode passes the caller's address with bits 1:0 cleared; keys live in SRAM
    wire [31:0] arg_sram   = {arg_ff[31:2], 2'b00};
    wire        new_sram   = I_WDATA[fscr_pkg::CTRL_BIT_SRAM];
    wire [31:0] arg_word   = new_sram ? arg_sram : arg_regs;
    // Request word built from the field positions, unused bits left zero
    logic [31:0] req_word;
    always_comb begin
        req_word = fscr_pkg::RST_WORD;
        req_word[fscr_pkg::OPC_LSB +: fscr_pkg::OPC_W] = opcode_ff;
        req_word[fscr_pkg::OPC_LSB + fscr_pkg::OPC_W +: 8] = fscr_pkg::OPC_HI_FILL;
        req_word[fscr_pkg::REQ_BIT_START] = 1'b1;
    end

    // ==========================================================
    // Poll and status decode
    wire flag_start = I_DEV_RDATA[fscr_pkg::REQ_BIT_START];
    wire flag_priv  = I_DEV_RDATA[fscr_pkg::REQ_BIT_PRIV];
    // Completion only once both flags have dropped
    wire call_end   = !flag_start && !flag_priv;
    wire time_up    = (timer_ff >= TIMEOUT_CYC - 1);
    wire stat_ok    = (I_DEV_RDATA[31:28] == fscr_pkg::STAT_OK_NIB);
    wire stat_fail  = (I_DEV_RDATA[31:8] == fscr_pkg::STAT_FAIL_MID);

    // ==========================================================
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_wdata = wdata_ff;
        unique case (state_ff)
            // Refused starts stay here; only the flags and the CTRL opcode and SRAM bit record them
            fscr_pkg::ST_IDLE: begin
                if (start_ok) begin
                    nxt_state = fscr_pkg::ST_WARG;
                    nxt_wdata = arg_word;
                end
            end
            // Keys or SRAM address first, so the call finds them in place
            fscr_pkg::ST_WARG: begin
                nxt_state = fscr_pkg::ST_WREQ;
                nxt_wdata = req_word;
            end
            // Setting the request bit hands control to the device
            fscr_pkg::ST_WREQ: begin
                nxt_state = fscr_pkg::ST_PRD;
            end
            // Read the request register; its answer arrives next cycle
            fscr_pkg::ST_PRD: begin
                nxt_state = fscr_pkg::ST_PCHK;
            end
            // Judge the answer: done, out of time or poll again
            fscr_pkg::ST_PCHK: begin
                if (call_end) begin
                    nxt_state = fscr_pkg::ST_SRD;
                end else if (time_up) begin
                    nxt_state = fscr_pkg::ST_IDLE;
                end else begin
                    nxt_state = fscr_pkg::ST_PRD;
                end
            end
            // Both flags dropped, so the argument now holds the status
            fscr_pkg::ST_SRD: begin
                nxt_state = fscr_pkg::ST_SCHK;
            end
            // Status word is on the device bus this cycle
            fscr_pkg::ST_SCHK: begin
                nxt_state = fscr_pkg::ST_IDLE;
            end
            // Only an illegal state code lands here
            default: begin
                nxt_state = fscr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            state_ff <= fscr_pkg::ST_IDLE;
            wdata_ff <= fscr_pkg::RST_WORD;
        end else begin
            state_ff <= nxt_state;
            wdata_ff <= nxt_wdata;
        end
    end

    // ==========================================================
    // Call set-up registers
    // Writes during a call are dropped, so each call sees one set of words
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            opcode_ff   <= 8'h00;
            use_sram_ff <= 1'b0;
            arg_ff      <= fscr_pkg::RST_WORD;
        end else begin
            if (wr_ctrl) begin
                opcode_ff   <= new_opc;
                use_sram_ff <= new_sram;
            end
            if (I_WR && sel_arg && is_idle) begin
                arg_ff <= I_WDATA;
            end
        end
    end

    // ==========================================================
    // One-second watchdog, restarted when the request is written
    // Saturates at the limit, so a very long call cannot wrap to zero
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N || state_ff == fscr_pkg::ST_WREQ) begin
            timer_ff <= 32'h0000_0000;
        end else if (!is_idle && !time_up) begin
            timer_ff <= timer_ff + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Results and completion flags
    // A timed-out call is left to the device; no status word is read
    wire poll_end  = (state_ff == fscr_pkg::ST_PCHK) && call_end;
    wire poll_abort = (state_ff == fscr_pkg::ST_PCHK) && !call_end && time_up;
    wire stat_take = (state_ff == fscr_pkg::ST_SCHK);

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            res_arg_ff <= fscr_pkg::RST_WORD;
            res_req_ff <= fscr_pkg::RST_WORD;
        end else begin
            // The request word at completion carries any result of the call
            if (poll_end) begin
                res_req_ff <= I_DEV_RDATA;
            end
            if (stat_take) begin
                res_arg_ff <= I_DEV_RDATA;
            end
        end
    end

    // Flags are rewritten by any start, accepted or refused, which cannot meet an end
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            done_ff    <= 1'b0;
            ok_ff      <= 1'b0;
            fail_ff    <= 1'b0;
            timeout_ff <= 1'b0;
            refused_ff <= 1'b0;
            code_ff    <= 8'h00;
        // A refused start finishes at once: done, fail and refused
        end else if (start_req) begin
            done_ff    <= start_bad;
            ok_ff      <= 1'b0;
            fail_ff    <= start_bad;
            timeout_ff <= 1'b0;
            refused_ff <= start_bad;
            code_ff    <= 8'h00;
        end else if (poll_abort) begin
            done_ff    <= 1'b1;
            fail_ff    <= 1'b1;
            timeout_ff <= 1'b1;
        end else if (stat_take) begin
            done_ff <= 1'b1;
            ok_ff   <= stat_ok;
            // Key errors and unknown opcodes come back as failure words
            fail_ff <= !stat_ok;
            code_ff <= stat_fail ? I_DEV_RDATA[7:0] : 8'h00;
        end
    end

    // ==========================================================
    // Software read-back, one cycle after the strobe
    // Unmapped addresses read as zero
    // Field positions come from the package so the map lives in one place
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;
    always_comb begin
        ctrl_view = fscr_pkg::RST_WORD;
        ctrl_view[fscr_pkg::OPC_LSB +: fscr_pkg::OPC_W] = opcode_ff;
        ctrl_view[fscr_pkg::CTRL_BIT_SRAM]              = use_sram_ff;
        stat_view = fscr_pkg::RST_WORD;
        stat_view[fscr_pkg::ST_BIT_BUSY]      = !is_idle;
        stat_view[fscr_pkg::ST_BIT_DONE]      = done_ff;
        stat_view[fscr_pkg::ST_BIT_OK]        = ok_ff;
        stat_view[fscr_pkg::ST_BIT_FAIL]      = fail_ff;
        stat_view[fscr_pkg::ST_BIT_TIMEOUT]   = timeout_ff;
        stat_view[fscr_pkg::ST_BIT_REFUSED]   = refused_ff;
        stat_view[fscr_pkg::ST_CODE_LSB +: 8] = code_ff;
    end

    wire [31:0] rd_mux = sel_ctrl    ? ctrl_view  :
                         sel_arg     ? arg_ff     :
                         sel_status  ? stat_view  :
                         sel_res_arg ? res_arg_ff :
                         sel_res_req ? res_req_ff : 32'h0000_0000;

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            rdata_ff <= fscr_pkg::RST_WORD;
        end else if (I_RD) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= fscr_pkg::RST_WORD;
        end
    end

    // ==========================================================
    // Outputs
    assign O_RDATA = rdata_ff;
    // Reset sources should stay quiet while a call may be writing flash
    assign O_CALL_BUSY = !is_idle;

    // At most one device strobe per state; only the request register is polled
    wire in_warg = (state_ff == fscr_pkg::ST_WARG);
    wire in_wreq = (state_ff == fscr_pkg::ST_WREQ);
    wire in_prd  = (state_ff == fscr_pkg::ST_PRD);
    wire in_srd  = (state_ff == fscr_pkg::ST_SRD);
    wire to_req  = in_wreq || in_prd;

    // Every flash write goes out as a call on the device register port
    assign O_DEV_REQ.wr    = in_warg || in_wreq;
    assign O_DEV_REQ.rd    = in_prd || in_srd;
    assign O_DEV_REQ.sel   = to_req ? fscr_pkg::DEV_SEL_REQ : fscr_pkg::DEV_SEL_ARG;
    assign O_DEV_REQ.wdata = wdata_ff;

endmodule

`default_nettype wire

/* File: tb/fscr_dev_model.sv */
/* Behavioural flash call device: argument and request registers.
   Assumes the requester keeps one strobe per cycle; run time is set per call. */
`default_nettype none
module fscr_dev_model (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_reset_n,
    // Register port and pacing
    input  wire fscr_pkg::fscr_dev_req_t i_req,
    input  wire logic [15:0]             i_run_cyc,
    output logic      [31:0]             o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Call decode
    logic [31:0] arg_ff;
    logic [31:0] req_ff;
    logic [31:0] last_ff;
    logic [15:0] cnt_ff;
    logic        rd_ff;
    wire  [7:0]  opc    = req_ff[7:0];
    wire         key_ok = arg_ff[15:0] == {8'hd3 + opc, 8'hb6};
    wire         known  = opc < 8'h20;
    // Outside the answer cycle the bus shows no stale word
    assign o_rdata = rd_ff ? last_ff : ~last_ff;
    always_ff @(posedge i_clk) begin
        rd_ff <= i_req.rd;
        if (i_req.rd) last_ff <= i_req.sel ? req_ff : arg_ff;
        if (!i_reset_n) begin
            arg_ff <= 32'h0;
            req_ff <= 32'h0;
            cnt_ff <= 16'h0;
        end else if (req_ff[31]) begin
            // Countdown stands in for program, erase, program from the latch
            // Only blocking calls reach this port, so no controller interrupt
            cnt_ff <= cnt_ff - 16'h1;
            if (cnt_ff == 16'h0) begin
                req_ff <= key_ok && known ? {16'h0, 8'h5a, opc} : {24'h0, opc};
                arg_ff <= !key_ok ? 32'hf0000001 : !known ? 32'hf0000002
                        : {4'ha, 12'h0, arg_ff[31:16]};
            end
        end else if (i_req.wr && i_req.sel && i_req.wdata[31]) begin
            req_ff <= i_req.wdata | 32'h1000_0000;
            cnt_ff <= i_run_cyc;
        end else if (i_req.wr && !i_req.sel) arg_ff <= i_req.wdata;
    end
endmodule
`default_nettype wire

/* File: tb/fscr_host_asserts.sv */
/* Port checker of the flash call requester, bound to fscr_host.
   Assumes the timeout parameter handed on from the bound instance. */
`default_nettype none
module fscr_host_asserts #(
    parameter int unsigned TIMEOUT_CYC = 40
) (
    // Clock, reset and software port
    input wire logic                    I_CLK,
    input wire logic                    I_RESET_N,
    input wire logic [4:0]              I_ADDR,
    input wire logic [31:0]             I_WDATA,
    input wire logic                    I_WR,
    input wire logic                    I_RD,
    input wire logic [31:0]             O_RDATA,
    // Device side
    input wire logic                    I_PROG_MODE,
    input wire logic                    O_CALL_BUSY,
    input wire fscr_pkg::fscr_dev_req_t O_DEV_REQ,
    input wire logic [31:0]             I_DEV_RDATA
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    // ==========================================
    // Length of a call, counted so a hung poll loop shows
    logic [31:0] busy_cnt_ff;
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N || !O_CALL_BUSY) busy_cnt_ff <= 32'h0;
        else busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end
    property p_rd_window; !$past(I_RD) |-> O_RDATA == 32'h0; endproperty
    property p_arg_req; O_DEV_REQ.wr && !O_DEV_REQ.sel |=> O_DEV_REQ.wr && O_DEV_REQ.sel;
    endproperty
    property p_req_word;
        O_DEV_REQ.wr && O_DEV_REQ.sel |-> O_DEV_REQ.wdata[31:8] == 24'h800000;
    endproperty
    property p_poll;
        O_DEV_REQ.wr && O_DEV_REQ.sel |=> O_DEV_REQ.rd && O_DEV_REQ.sel ##1 !O_DEV_REQ.rd
            ##1 O_DEV_REQ.rd;
    endproperty
    property p_fetch;
        $past(O_DEV_REQ.rd) && $past(O_DEV_REQ.sel) && !I_DEV_RDATA[31] && !I_DEV_RDATA[28]
            |=> O_DEV_REQ.rd && !O_DEV_REQ.sel ##2 !O_CALL_BUSY;
    endproperty
    property p_quiet; !O_CALL_BUSY |-> !O_DEV_REQ.wr && !O_DEV_REQ.rd; endproperty
    property p_refuse; !O_CALL_BUSY && !I_PROG_MODE |=> !O_CALL_BUSY; endproperty
    property p_once; O_DEV_REQ.wr && O_DEV_REQ.sel |=> !O_DEV_REQ.wr until !O_CALL_BUSY;
    endproperty
    property p_limit; busy_cnt_ff <= TIMEOUT_CYC + 6; endproperty
    a_rd_window: assert property (p_rd_window) else $error("read data outside window");
    a_arg_req: assert property (p_arg_req) else $error("request write missing");
    a_req_word: assert property (p_req_word) else $error("bad request word");
    a_poll: assert property (p_poll) else $error("flag poll missing");
    a_fetch: assert property (p_fetch) else $error("status not fetched");
    a_quiet: assert property (p_quiet) else $error("device access while idle");
    a_refuse: assert property (p_refuse) else $error("call outside programming mode");
    a_once: assert property (p_once) else $error("second write within a call");
    a_limit: assert property (p_limit) else $error("call outlived its timeout");
    c_fetch: cover property (p_fetch);
    c_limit: cover property (busy_cnt_ff == TIMEOUT_CYC);
    c_refuse: cover property (I_WR && I_ADDR == 5'h00 && I_WDATA[31] && !I_PROG_MODE);
endmodule
bind fscr_host fscr_host_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PROG_MODE(I_PROG_MODE),
    .O_CALL_BUSY(O_CALL_BUSY), .O_DEV_REQ(O_DEV_REQ), .I_DEV_RDATA(I_DEV_RDATA));
`default_nettype wire

/* File: tb/test_flash_syscall_request.sv */
/* Self-checking bench of the flash call requester against the device model.
   Assumes a 20 MHz clock and a shortened timeout of 40 cycles. */
`default_nettype none
module test_flash_syscall_request;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_n = 1'b0;
    logic [4:0] addr = 5'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic prog = 1'b1;
    logic [15:0] run_cyc = 16'h0;
    logic [31:0] rdata;
    logic [31:0] dev_rdata;
    logic busy;
    fscr_pkg::fscr_dev_req_t dreq;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 45;
    fscr_host #(.TIMEOUT_CYC(40)) uut (.I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PROG_MODE(prog),
        .O_CALL_BUSY(busy), .O_DEV_REQ(dreq), .I_DEV_RDATA(dev_rdata));
    fscr_dev_model u_dev (.i_clk(clk), .i_reset_n(rst_n), .i_req(dreq),
        .i_run_cyc(run_cyc), .o_rdata(dev_rdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================
    // Bus tasks; one idle edge before each strobe keeps drivers single per step
    task automatic sw_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic sw_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Read data stand in the cycle after the strobe; take them at its end
        @(posedge clk);
        d = rdata;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_idle;
        logic [31:0] d;
        int n;
        n = 0;
        sw_rd(fscr_pkg::OFS_STATUS, d);
        while (d[0] !== 1'b0 && n < 200) begin
            sw_rd(fscr_pkg::OFS_STATUS, d);
            n++;
        end
        if (n >= 200) n_fail++;
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // One call, expectations reckoned from keys, opcode set and status format
    task automatic run_call(input logic [7:0] opc, input logic [31:0] a, input logic sram,
                            input logic [15:0] run);
        logic [31:0] sent;
        logic [31:0] ea;
        logic [31:0] d;
        logic ok;
        sent = sram ? {a[31:2], 2'b00} : {a[31:16], 8'hd3 + opc, 8'hb6};
        ea = sent[15:0] != {8'hd3 + opc, 8'hb6} ? 32'hf0000001
           : opc >= 8'h20 ? 32'hf0000002 : {4'ha, 12'h0, sent[31:16]};
        ok = ea[31:28] == 4'ha;
        run_cyc <= run;
        sw_wr(fscr_pkg::OFS_ARG, a);
        sw_wr(fscr_pkg::OFS_CTRL, {1'b1, 22'h0, sram, opc});
        sw_wr(fscr_pkg::OFS_ARG, ~a);
        wait_idle;
        sw_rd(fscr_pkg::OFS_STATUS, d);
        chk(d, ok ? 32'h6 : {16'h0, ea[7:0], 8'h0a});
        sw_rd(fscr_pkg::OFS_RES_ARG, d);
        chk(d, ea);
        sw_rd(fscr_pkg::OFS_RES_REQ, d);
        chk(d, ok ? {16'h0, 8'h5a, opc} : {24'h0, opc});
        sw_rd(fscr_pkg::OFS_ARG, d);
        chk(d, a);
    endtask
    initial begin
        #(50 * 20000);
        n_fail++;
        wrap_up;
    end
    initial begin
        logic [31:0] d;
        logic [7:0] nb [3];
        nb = '{8'hff, 8'hfe, 8'hfd};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        sw_rd(fscr_pkg::OFS_STATUS, d);
        chk(d, fscr_pkg::RST_WORD);
        sw_rd(5'h14, d);
        chk(d, 32'h0);
        sw_wr(fscr_pkg::OFS_CTRL, 32'h137);
        sw_rd(fscr_pkg::OFS_CTRL, d);
        chk(d, 32'h137);
        for (int i = 0; i < 6; i++) begin
            run_call($random(seed) & 8'h1f, $random(seed), 1'b0, $random(seed) & 16'hf);
        end
        run_call(8'h40, 32'h1234_0000, 1'b0, 16'h3);
        run_call(8'h05, 32'h2000_d8b6, 1'b1, 16'h2);
        run_cyc <= 16'd300;
        sw_wr(fscr_pkg::OFS_CTRL, 32'h8000_0001);
        wait_idle;
        sw_rd(fscr_pkg::OFS_STATUS, d);
        chk(d, 32'h1a);
        repeat (320) @(posedge clk);
        prog <= 1'b0;
        sw_wr(fscr_pkg::OFS_CTRL, 32'h8000_0001);
        sw_rd(fscr_pkg::OFS_STATUS, d);
        chk(d, 32'h2a);
        prog <= 1'b1;
        foreach (nb[k]) begin
            sw_wr(fscr_pkg::OFS_CTRL, {24'h800000, nb[k]});
            sw_rd(fscr_pkg::OFS_STATUS, d);
            chk(d, 32'h2a);
        end
        wrap_up;
    end
endmodule
`default_nettype wire
